// File: lldes_pkg.sv
// Package for the link-layer debug and error-status register group.
// Assumes a single 20 MHz system clock and a plain strobe register port.
package lldes_pkg;

    localparam logic [31:0] LLDES_DIAG_STAT_OFS = 32'h40000054;
    localparam logic [31:0] LLDES_ZONE_UPPER_OFS = 32'h40000058;
    localparam logic [31:0] LLDES_ZONE_LOWER_OFS = 32'h4000005C;
    localparam logic [31:0] LLDES_ERR_TYPE_OFS = 32'h40000060;
    localparam logic [31:0] LLDES_IRQ_STAT_OFS = 32'h40000100;
    localparam logic [31:0] LLDES_IRQ_CLR_OFS = 32'h40000104;
    localparam logic [31:0] LLDES_IRQ_EN_OFS = 32'h40000108;
    localparam logic [31:0] LLDES_LANE_EN_OFS = 32'h4000010C;

    localparam logic [31:0] LLDES_RESET_WORD = 32'h00000000;
    localparam logic [11:0] LLDES_ERR_RESET = 12'h000;
    localparam logic [3:0] LLDES_LANE_EN_RESET = 4'h0;

    localparam int LLDES_ERR_LSB = 6;
    localparam int LLDES_ERR_NUM = 12;
    localparam int LLDES_LANE_NUM = 4;
    localparam int LLDES_LANE_W = 8;
    localparam int LLDES_ZONE_W = 16;
    localparam int LLDES_REG_ZONE_LSB = 16;
    localparam int LLDES_MEM_ZONE_LSB = 0;
    localparam int LLDES_ZONE_HIT_LSB = 16;

    // Error event bit order, bit 0 = error-type bit 6 ... bit 11 = bit 17
    typedef struct packed {
        logic eventIrqOverlapErr;
        logic rxBufferPtrZeroErr;
        logic txBufferPtrZeroErr;
        logic rxDescriptorZeroErr;
        logic txDescriptorZeroErr;
        logic ctrlStructFormatErr;
        logic channelMapCountErr;
        logic advertIntervalShort;
        logic interframeGapShort;
        logic allowListTimeout;
        logic evtCtrlPrefetchErr;
        logic schedulerPrefetchErr;
    } lldes_err_type;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } lldes_bus_type;

    typedef struct packed {
        logic [LLDES_ZONE_W-1:0] registerZone;
        logic [LLDES_ZONE_W-1:0] xchgMemZone;
    } lldes_zone_type;

endpackage

// File: lldes_regs.sv
// Debug lanes, address-zone limits with in-zone flags, and error-type status.
// Assumes error pulses, debug lanes and probe addresses are synchronous to mclk.
// How it works
// - Status register bytes mirror debug lanes three down to zero.
// - Register-zone flag uses upper halves of max and min limit registers.
// - Memory-zone flag uses lower halves; limits read/write, reset zero.
// - Bit 17 flags unacknowledged overlapping link event interrupts.
// - Bit 16 flags a zero receive buffer pointer.
// - Bit 15 flags a zero transmit buffer pointer in active events.
// - Bit 14 flags a zero receive descriptor pointer.
// - Bit 13 flags a zero transmit descriptor pointer.
// - Bit 12 flags an unsupported control-structure format.
// - Bit 11 flags channel-map ones count mismatching good-channel count.
// - Bit 10 flags an advertising interval underrun.
// - Bit 9 flags an inter-frame gap underrun.
// - Bit 8 flags an allow-list parsing timeout.
// - Bits 7 and 6 flag controller and scheduler pre-fetch conflicts.
// - A disabled lane outputs zero, so its status byte reads zero.
//
// The address-and-strobe port is this design's own decision.
module lldes_regs
    import lldes_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire lldes_bus_type busIn,
    output logic [31:0] rdData,
    input wire logic [31:0] laneSourceIn,
    input wire lldes_err_type errEvent,
    input wire logic [15:0] regProbeAddr,
    input wire logic [15:0] memProbeAddr,
    output logic [31:0] debugLanesOut,
    output logic registerZoneHit,
    output logic xchgMemZoneHit,
    output logic irqOut
);

    logic [31:0] rdData_r;
    logic [31:0] laneOut_r;
    logic [3:0] laneEn_r;
    lldes_zone_type upper_r;
    lldes_zone_type lower_r;
    logic [11:0] errStat_r;
    logic [11:0] irqStat_r;
    logic [11:0] irqEn_r;
    logic regHit_r;
    logic memHit_r;
    logic irq_r;
    logic [11:0] errBits;
    logic wrUpper;
    logic wrLower;
    logic wrClr;
    logic wrEn;
    logic wrLaneEn;

    assign errBits = errEvent;
    assign wrUpper = busIn.wr && (busIn.addr == LLDES_ZONE_UPPER_OFS);
    assign wrLower = busIn.wr && (busIn.addr == LLDES_ZONE_LOWER_OFS);
    assign wrClr = busIn.wr && (busIn.addr == LLDES_IRQ_CLR_OFS);
    assign wrEn = busIn.wr && (busIn.addr == LLDES_IRQ_EN_OFS);
    assign wrLaneEn = busIn.wr && (busIn.addr == LLDES_LANE_EN_OFS);

    // Each lane is registered so the status byte equals the pin byte exactly
    genvar g;
    generate
        for (g = 0; g < LLDES_LANE_NUM; g++) begin : gLane
            always_ff @(posedge mclk) begin
                if (!rstn) begin
                    laneOut_r[g*LLDES_LANE_W +: LLDES_LANE_W] <= 8'h00;
                end else if (laneEn_r[g]) begin
                    laneOut_r[g*LLDES_LANE_W +: LLDES_LANE_W] <=
                        laneSourceIn[g*LLDES_LANE_W +: LLDES_LANE_W];
                end else begin
                    laneOut_r[g*LLDES_LANE_W +: LLDES_LANE_W] <= 8'h00;
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            laneEn_r <= LLDES_LANE_EN_RESET;
        end else if (wrLaneEn) begin
            laneEn_r <= busIn.wdata[3:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            upper_r <= LLDES_RESET_WORD;
            lower_r <= LLDES_RESET_WORD;
        end else begin
            if (wrUpper) begin
                upper_r <= busIn.wdata;
            end
            if (wrLower) begin
                lower_r <= busIn.wdata;
            end
        end
    end

    // Inclusive bounds; an inverted window (lower above upper) never hits
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            regHit_r <= 1'b0;
            memHit_r <= 1'b0;
        end else begin
            regHit_r <= (regProbeAddr >= lower_r.registerZone)
                && (regProbeAddr <= upper_r.registerZone);
            memHit_r <= (memProbeAddr >= lower_r.xchgMemZone)
                && (memProbeAddr <= upper_r.xchgMemZone);
        end
    end

    // Error bits are sticky for the diagnosis; only reset clears them
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            errStat_r <= LLDES_ERR_RESET;
        end else begin
            errStat_r <= errStat_r | errBits;
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            irqStat_r <= LLDES_ERR_RESET;
        end else if (wrClr) begin
            irqStat_r <= (irqStat_r & ~busIn.wdata[LLDES_ERR_LSB +: LLDES_ERR_NUM]) | errBits;
        end else begin
            irqStat_r <= irqStat_r | errBits;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            irqEn_r <= LLDES_ERR_RESET;
        end else if (wrEn) begin
            irqEn_r <= busIn.wdata[LLDES_ERR_LSB +: LLDES_ERR_NUM];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |((irqStat_r | errBits) & irqEn_r);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rdData_r <= LLDES_RESET_WORD;
        end else if (busIn.rd) begin
            unique case (busIn.addr)
                LLDES_DIAG_STAT_OFS: rdData_r <= laneOut_r;
                LLDES_ZONE_UPPER_OFS: rdData_r <= upper_r;
                LLDES_ZONE_LOWER_OFS: rdData_r <= lower_r;
                LLDES_ERR_TYPE_OFS: rdData_r <= {14'h0000, errStat_r, 6'h00};
                LLDES_IRQ_STAT_OFS: rdData_r <= {14'h0000, irqStat_r, 6'h00};
                LLDES_IRQ_EN_OFS: rdData_r <= {14'h0000, irqEn_r, 6'h00};
                LLDES_LANE_EN_OFS: rdData_r <= {28'h0000000, laneEn_r};
                default: rdData_r <= LLDES_RESET_WORD;
            endcase
        end else begin
            rdData_r <= LLDES_RESET_WORD;
        end
    end

    assign rdData = rdData_r;
    assign debugLanesOut = laneOut_r;
    assign registerZoneHit = regHit_r;
    assign xchgMemZoneHit = memHit_r;
    assign irqOut = irq_r;

    chk_lane_mirror: assert property (@(posedge mclk) disable iff (!rstn)
        laneEn_r[0] |=> laneOut_r[7:0] == $past(laneSourceIn[7:0]))
        else $error("lane 0 does not mirror its source");
    chk_lane_off_zero: assert property (@(posedge mclk) disable iff (!rstn)
        !laneEn_r[3] |=> laneOut_r[31:24] == 8'h00)
        else $error("disabled lane not zero");
    chk_reg_zone_hit: assert property (@(posedge mclk) disable iff (!rstn)
        (regProbeAddr >= lower_r.registerZone && regProbeAddr <= upper_r.registerZone
         && !wrUpper && !wrLower) |=> regHit_r)
        else $error("register zone hit missed");
    chk_mem_zone_hit: assert property (@(posedge mclk) disable iff (!rstn)
        (memProbeAddr < lower_r.xchgMemZone) |=> !memHit_r)
        else $error("memory zone hit below limit");
    chk_overlap_err: assert property (@(posedge mclk) disable iff (!rstn)
        errEvent.eventIrqOverlapErr |=> errStat_r[11] [*2])
        else $error("overlap error not sticky");
    chk_rxptr_err: assert property (@(posedge mclk) disable iff (!rstn)
        errEvent.rxBufferPtrZeroErr |=> busIn.rd && busIn.addr == LLDES_ERR_TYPE_OFS
        |=> rdData_r[16])
        else $error("rx pointer error not read back");
    chk_txptr_err: assert property (@(posedge mclk) disable iff (!rstn)
        errEvent.txBufferPtrZeroErr |=> errStat_r[9])
        else $error("tx pointer error not set");
    chk_prefetch_err: assert property (@(posedge mclk) disable iff (!rstn)
        errEvent.schedulerPrefetchErr |-> ##2 errStat_r[0])
        else $error("scheduler prefetch error lost");
    chk_irq_level: assert property (@(posedge mclk) disable iff (!rstn)
        (errEvent.allowListTimeout && irqEn_r[2] && !wrEn) |=> irq_r)
        else $error("enabled error did not raise interrupt");

endmodule // lldes_regs

// File: lldes_regs_tb.sv
// Self-checking testbench for the link-layer debug and error-status registers.
// Assumes lldes_pkg offsets and the one-cycle read latency of lldes_regs.
module testbench;
    import lldes_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic mclk;
    logic rstn;
    lldes_bus_type busIn;
    logic [31:0] rdData;
    logic [31:0] laneSourceIn;
    logic [31:0] debugLanesOut;
    lldes_err_type errEvent;
    logic [15:0] regProbeAddr;
    logic [15:0] memProbeAddr;
    logic registerZoneHit;
    logic xchgMemZoneHit;
    logic irqOut;
    logic [11:0] errMask;
    int error_cnt;
    int checks_done;

    lldes_regs dut_u (
        .mclk(mclk),
        .rstn(rstn),
        .busIn(busIn),
        .rdData(rdData),
        .laneSourceIn(laneSourceIn),
        .errEvent(errEvent),
        .regProbeAddr(regProbeAddr),
        .memProbeAddr(memProbeAddr),
        .debugLanesOut(debugLanesOut),
        .registerZoneHit(registerZoneHit),
        .xchgMemZoneHit(xchgMemZoneHit),
        .irqOut(irqOut)
    );

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic check_val(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("Checks: %0d, mismatches: %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        busIn.addr <= a;
        busIn.wdata <= d;
        busIn.wr <= 1'b1;
        @(posedge mclk);
        busIn.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample there
    task automatic bus_rd(input logic [31:0] a, input logic [31:0] exp);
        @(posedge mclk);
        busIn.addr <= a;
        busIn.rd <= 1'b1;
        @(posedge mclk);
        busIn.rd <= 1'b0;
        @(negedge mclk);
        check_val(rdData, exp);
    endtask

    // Registered outputs follow their inputs one edge late
    task automatic settle();
        repeat (2) @(posedge mclk);
        #1;
    endtask

    task automatic pulse_err(input int i);
        @(posedge mclk);
        errEvent <= lldes_err_type'(12'h001 << i);
        @(posedge mclk);
        errEvent <= '0;
    endtask

    task automatic probe(input logic [15:0] r, input logic [15:0] m, input logic [31:0] exp);
        @(posedge mclk);
        regProbeAddr <= r;
        memProbeAddr <= m;
        settle();
        check_val({30'h0, registerZoneHit, xchgMemZoneHit}, exp);
    endtask

    // Whole sequence takes well under 1000 cycles; 2000 cycles means a hang
    initial begin
        #100000;
        error_cnt++;
        print_verdict();
    end

    initial begin
        rstn = 1'b0;
        busIn = '0;
        laneSourceIn = 32'hA5C33C5A;
        errEvent = '0;
        regProbeAddr = 16'h0000;
        memProbeAddr = 16'h0000;
        errMask = '0;
        error_cnt = 0;
        checks_done = 0;
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        bus_rd(LLDES_DIAG_STAT_OFS, 32'h0);
        bus_rd(LLDES_ZONE_UPPER_OFS, 32'h0);
        bus_rd(LLDES_ZONE_LOWER_OFS, 32'h0);
        bus_rd(LLDES_ERR_TYPE_OFS, 32'h0);
        bus_wr(LLDES_LANE_EN_OFS, 32'h0000000F);
        settle();
        check_val(debugLanesOut, 32'hA5C33C5A);
        bus_rd(LLDES_DIAG_STAT_OFS, 32'hA5C33C5A);
        bus_wr(LLDES_LANE_EN_OFS, 32'h0000000D);
        settle();
        bus_rd(LLDES_DIAG_STAT_OFS, 32'hA5C3005A);
        bus_wr(LLDES_DIAG_STAT_OFS, 32'hFFFFFFFF);
        bus_rd(LLDES_DIAG_STAT_OFS, 32'hA5C3005A);
        bus_wr(LLDES_ZONE_UPPER_OFS, 32'h20000100);
        bus_wr(LLDES_ZONE_LOWER_OFS, 32'h10000080);
        bus_rd(LLDES_ZONE_UPPER_OFS, 32'h20000100);
        bus_rd(LLDES_ZONE_LOWER_OFS, 32'h10000080);
        probe(16'h1000, 16'h0100, 32'h3);
        probe(16'h2000, 16'h0080, 32'h3);
        probe(16'h2001, 16'h007F, 32'h0);
        probe(16'h0100, 16'h1000, 32'h0);
        for (int i = 0; i < LLDES_ERR_NUM; i++) begin
            pulse_err(i);
            errMask[i] = 1'b1;
            bus_rd(LLDES_ERR_TYPE_OFS, {14'h0, errMask, 6'h0});
        end
        check_val({31'h0, irqOut}, 32'h0);
        bus_wr(LLDES_ERR_TYPE_OFS, 32'h0);
        bus_rd(LLDES_ERR_TYPE_OFS, 32'h0003FFC0);
        bus_rd(32'h40000070, 32'h0);
        bus_wr(LLDES_IRQ_EN_OFS, 32'h0003FFC0);
        settle();
        check_val({31'h0, irqOut}, 32'h1);
        bus_rd(LLDES_IRQ_STAT_OFS, 32'h0003FFC0);
        bus_wr(LLDES_IRQ_CLR_OFS, 32'h0003FFC0);
        bus_rd(LLDES_IRQ_STAT_OFS, 32'h0);
        check_val({31'h0, irqOut}, 32'h0);
        bus_rd(LLDES_ERR_TYPE_OFS, 32'h0003FFC0);
        bus_wr(LLDES_IRQ_EN_OFS, 32'h0);
        pulse_err(11);
        settle();
        check_val({31'h0, irqOut}, 32'h0);
        bus_wr(LLDES_IRQ_EN_OFS, 32'h00020000);
        settle();
        check_val({31'h0, irqOut}, 32'h1);
        print_verdict();
    end
endmodule // testbench
